// file: core/ccl_pkg.sv
package ccl_pkg;

   // Register addresses on the plain register port
   localparam logic [7:0] CCL_ADDR_CTRL0 = 8'h19;
   localparam logic [7:0] CCL_ADDR_CTRL1 = 8'h1A;
   localparam logic [7:0] CCL_ADDR_IRQ = 8'h1B;
   localparam logic [7:0] CCL_ADDR_REF = 8'h1C;

   // Control register 0 field positions
   localparam int CCL_C0_MODE_LSB = 0;
   localparam int CCL_C0_SWITCH = 3;
   localparam int CCL_C0_INVERT = 4;
   localparam int CCL_C0_RESULT = 6;

   // Control register 1 field positions
   localparam int CCL_C1_SYNC = 0;
   localparam int CCL_C1_GATE = 1;

   // Interrupt register field positions
   localparam int CCL_IRQ_FLAG = 0;
   localparam int CCL_IRQ_IE = 1;
   localparam int CCL_IRQ_PE = 2;
   localparam int CCL_IRQ_GE = 3;

   // Reference register field positions
   localparam int CCL_REF_VAL_LSB = 0;
   localparam int CCL_REF_RANGE = 5;
   localparam int CCL_REF_EN = 7;

   // Values after reset
   localparam logic [2:0] CCL_RST_MODE = 3'h0;
   localparam logic CCL_RST_GATE_SEL = 1'b1;
   localparam logic CCL_RST_SYNC = 1'b0;
   localparam logic [3:0] CCL_RST_REF_VAL = 4'h0;

   // Synchroniser lanes: comparator, external gate, timer clocks
   localparam int CCL_LANE_CMP = 0;
   localparam int CCL_LANE_GATE = 1;
   localparam int CCL_LANE_TSRC = 2;
   localparam int CCL_LANE_TPRE = 3;
   localparam int CCL_LANES = 4;

   // Comparator operating modes
   typedef enum logic [2:0] {
      CCL_MODE_RESET = 3'h0,
      CCL_MODE_PINS_OUT = 3'h1,
      CCL_MODE_REF = 3'h2,
      CCL_MODE_REF_OUT = 3'h3,
      CCL_MODE_PINS = 3'h4,
      CCL_MODE_MUX_OUT = 3'h5,
      CCL_MODE_MUX = 3'h6,
      CCL_MODE_OFF = 3'h7
   } ccl_mode_type;

   // Analog switch controls handed to the comparator core
   typedef struct packed {
      logic cmp_en;
      logic plus_from_ref;
      logic minus_from_ref;
      logic ext_from_pos;
      logic ext_from_neg;
      logic pin_out_en;
   } ccl_mux_type;

   // Register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ccl_bus_type;

   // Whole state of the block
   typedef struct packed {
      ccl_mode_type mode;
      logic invert;
      logic input_switch;
      logic gate_sel;
      logic sync_en;
      logic change_flag;
      logic irq_en;
      logic periph_en;
      logic global_en;
      logic ref_en;
      logic ref_range;
      logic [3:0] ref_val;
      logic [CCL_LANES-1:0] sync1;
      logic [CCL_LANES-1:0] sync2;
      logic tclk_d;
      logic pre_en_d;
      logic [1:0] port_s1;
      logic [1:0] port_s2;
      logic latched;
      logic captured;
      logic [7:0] rdata;
   } ccl_state_type;

endpackage : ccl_pkg

// file: core/ccl_comparator_ctrl.sv
// Function
// - Result high when plus exceeds minus
// - Invert bit flips status and pin
// - Result bit read only, writes ignored
// - Modes 000 and 111 off, read zero
// - Modes 010, 100, 001 routing
// - Modes 011, 101, 110 routing
// - Switch bit picks external multiplexed input
// - Analog pins read zero on port
// - Raw result to pin, direction enables
// - Gate select: pin or comparator, resets 1
// - Optional latch on timer clock fall
// - Timer clock drives the latch, prescaled one when enabled
// - Flag sets on mismatch, enables ignored
// - Software clears with 0, 1 sets
// - Request needs flag and three enables
// - Control 0 access recaptures, ends mismatch
// - Change during read may be missed
// - Reference gives 32 levels, two ranges
// - Reset forces mode 000, reference off
// - Runs in sleep, change wakes device
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps

module ccl_comparator_ctrl
   import ccl_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Register port
   input wire ccl_bus_type bus_i,
   output logic [7:0] reg_rdata_o,
   // Analog comparator core
   input wire logic cmp_raw_i,
   output ccl_mux_type mux_o,
   output logic ref_en_o,
   output logic ref_range_o,
   output logic [3:0] ref_val_o,
   // Port pins
   input wire logic [1:0] gpio_in_i,
   output logic [1:0] gpio_read_o,
   input wire logic out_dir_i,
   output logic output_pin_o,
   output logic output_pin_oe_o,
   // Timer interface
   input wire logic timer_src_clk_i,
   input wire logic timer_pre_clk_i,
   input wire logic timer_pre_en_i,
   input wire logic external_gate_pin_i,
   output logic timer_gate_o,
   // Interrupt and wake
   output logic irq_o,
   output logic wake_o
);

   ccl_state_type st_r;
   ccl_state_type st_nxt;

   logic mode_on;
   logic pin_mode;
   logic raw_inv;
   logic live_result;
   logic cmp_result;
   logic tclk_sel;
   logic tclk_fall;
   logic ctrl0_access;
   logic mismatch;
   logic [CCL_LANES-1:0] async_in;
   logic [7:0] ctrl0_view;
   logic [7:0] ctrl1_view;
   logic [7:0] irq_view;
   logic [7:0] ref_view;
   logic tclk_steady;
   logic flag_set;

   // Asynchronous inputs entering the synchroniser lanes
   assign async_in[CCL_LANE_CMP] = cmp_raw_i;
   assign async_in[CCL_LANE_GATE] = external_gate_pin_i;
   assign async_in[CCL_LANE_TSRC] = timer_src_clk_i;
   assign async_in[CCL_LANE_TPRE] = timer_pre_clk_i;

   // Mode decode: both off modes keep the comparator idle
   always_comb begin
      mode_on = 1'b1;
      pin_mode = 1'b0;
      mux_o = '0;
      gpio_read_o = st_r.port_s2; // Pins reach the port via two flops
      case (st_r.mode)
         CCL_MODE_RESET, CCL_MODE_OFF: begin
            mode_on = 1'b0;
            gpio_read_o = 2'h0;
         end
         CCL_MODE_PINS_OUT: begin
            mux_o.ext_from_pos = 1'b1;
            mux_o.ext_from_neg = 1'b1;
            pin_mode = 1'b1;
            gpio_read_o = 2'h0;
         end
         CCL_MODE_PINS: begin
            mux_o.ext_from_pos = 1'b1;
            mux_o.ext_from_neg = 1'b1;
            gpio_read_o = 2'h0;
         end
         CCL_MODE_REF: begin
            mux_o.plus_from_ref = 1'b1;
            mux_o.ext_from_neg = 1'b1;
            gpio_read_o[1] = 1'b0;
         end
         CCL_MODE_REF_OUT: begin
            mux_o.plus_from_ref = 1'b1;
            mux_o.ext_from_neg = 1'b1;
            pin_mode = 1'b1;
            gpio_read_o[1] = 1'b0;
         end
         CCL_MODE_MUX_OUT, CCL_MODE_MUX: begin
            // Chosen pin goes to the negative side, reference opposite
            mux_o.plus_from_ref = 1'b1;
            mux_o.ext_from_pos = st_r.input_switch;
            mux_o.ext_from_neg = ~st_r.input_switch;
            pin_mode = (st_r.mode == CCL_MODE_MUX_OUT);
            gpio_read_o = 2'h0;
         end
         default: begin
            mode_on = 1'b0;
            gpio_read_o = 2'h0;
         end
      endcase
      mux_o.cmp_en = mode_on;
      mux_o.pin_out_en = pin_mode;
   end

   // Pin path is deliberately unsynchronised: it carries the raw edge
   // with no clock latency, so glitches near the threshold reach the pin
   assign raw_inv = cmp_raw_i ^ st_r.invert;
   assign output_pin_o = pin_mode & mode_on & raw_inv;
   assign output_pin_oe_o = pin_mode & ~out_dir_i;

   // Synchronised and optionally latched result seen by logic
   assign live_result = st_r.sync2[CCL_LANE_CMP] ^ st_r.invert;
   assign cmp_result = mode_on &
      (st_r.sync_en ? st_r.latched : live_result);

   // Timer clock for the latch: prescaler output when it is in use.
   // Swapping sources at unequal levels would look like a fall, so no
   // edge is taken in the cycle in which the selection changes
   assign tclk_sel = timer_pre_en_i ? st_r.sync2[CCL_LANE_TPRE] :
      st_r.sync2[CCL_LANE_TSRC];
   assign tclk_steady = (timer_pre_en_i == st_r.pre_en_d);
   assign tclk_fall = tclk_steady & st_r.tclk_d & ~tclk_sel;

   // Gate source for the timer; software should pick the synced result
   assign timer_gate_o = st_r.gate_sel ?
      st_r.sync2[CCL_LANE_GATE] : cmp_result;

   // Control register 0 accesses and mismatch tracking
   assign ctrl0_access = (bus_i.rd | bus_i.wr) &
      (bus_i.addr == CCL_ADDR_CTRL0);
   assign mismatch = (cmp_result != st_r.captured);

   // A mismatch sets the flag, except in a cycle that accesses
   // control 0: that access is the capture point itself
   assign flag_set = mismatch & ~ctrl0_access;

   // Read view of control register 0; result bit is the synchronised, optionally latched result
   assign ctrl0_view = {1'b0, cmp_result, 1'b0, st_r.invert,
      st_r.input_switch, st_r.mode};

   // Read views of the other registers; unused bits read zero
   always_comb begin
      ctrl1_view = 8'h00;
      ctrl1_view[CCL_C1_GATE] = st_r.gate_sel;
      ctrl1_view[CCL_C1_SYNC] = st_r.sync_en;
      irq_view = 8'h00;
      irq_view[CCL_IRQ_FLAG] = st_r.change_flag;
      irq_view[CCL_IRQ_IE] = st_r.irq_en;
      irq_view[CCL_IRQ_PE] = st_r.periph_en;
      irq_view[CCL_IRQ_GE] = st_r.global_en;
      ref_view = 8'h00;
      ref_view[CCL_REF_EN] = st_r.ref_en;
      ref_view[CCL_REF_RANGE] = st_r.ref_range;
      ref_view[CCL_REF_VAL_LSB +: 4] = st_r.ref_val;
   end

   // Next state of every register in the block
   always_comb begin
      st_nxt = st_r;

      // Two stage synchronisers; stage one feeds only stage two
      st_nxt.sync1 = async_in;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.port_s1 = gpio_in_i;
      st_nxt.port_s2 = st_r.port_s1;

      // Falling edge of the timer clock latches the result, so the
      // timer's rising edge never sees it mid-change
      st_nxt.tclk_d = tclk_sel;
      st_nxt.pre_en_d = timer_pre_en_i;
      if (tclk_fall) begin
         st_nxt.latched = live_result;
      end

      // Control 0 access recaptures the result; a change landing in
      // this same cycle is swallowed and never flagged
      if (ctrl0_access) begin
         st_nxt.captured = cmp_result;
      end

      // Register writes
      if (bus_i.wr) begin
         case (bus_i.addr)
            CCL_ADDR_CTRL0: begin
               st_nxt.mode = ccl_mode_type'(
                  bus_i.wdata[CCL_C0_MODE_LSB +: 3]);
               st_nxt.input_switch = bus_i.wdata[CCL_C0_SWITCH];
               st_nxt.invert = bus_i.wdata[CCL_C0_INVERT];
            end
            CCL_ADDR_CTRL1: begin
               st_nxt.gate_sel = bus_i.wdata[CCL_C1_GATE];
               st_nxt.sync_en = bus_i.wdata[CCL_C1_SYNC];
            end
            CCL_ADDR_IRQ: begin
               st_nxt.change_flag = bus_i.wdata[CCL_IRQ_FLAG];
               st_nxt.irq_en = bus_i.wdata[CCL_IRQ_IE];
               st_nxt.periph_en = bus_i.wdata[CCL_IRQ_PE];
               st_nxt.global_en = bus_i.wdata[CCL_IRQ_GE];
            end
            CCL_ADDR_REF: begin
               st_nxt.ref_en = bus_i.wdata[CCL_REF_EN];
               st_nxt.ref_range = bus_i.wdata[CCL_REF_RANGE];
               st_nxt.ref_val = bus_i.wdata[CCL_REF_VAL_LSB +: 4];
            end
            default: begin
               st_nxt.rdata = st_r.rdata;
            end
         endcase
      end

      // Hardware set wins over a software clear in the same cycle;
      // the mismatch keeps setting until control 0 is accessed
      if (flag_set) begin
         st_nxt.change_flag = 1'b1;
      end

      // Read data lands one cycle after the strobe; idle reads zero
      st_nxt.rdata = 8'h00;
      if (bus_i.rd) begin
         case (bus_i.addr)
            CCL_ADDR_CTRL0: begin
               st_nxt.rdata = ctrl0_view;
            end
            CCL_ADDR_CTRL1: begin
               st_nxt.rdata = ctrl1_view;
            end
            CCL_ADDR_IRQ: begin
               st_nxt.rdata = irq_view;
            end
            CCL_ADDR_REF: begin
               st_nxt.rdata = ref_view;
            end
            default: begin
               st_nxt.rdata = 8'h00;
            end
         endcase
      end
   end

   // State register; only reset touches the controls, so a wake from
   // sleep leaves every setting as it was
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r <= '0;
         st_r.mode <= ccl_mode_type'(CCL_RST_MODE);
         st_r.gate_sel <= CCL_RST_GATE_SEL;
         st_r.sync_en <= CCL_RST_SYNC;
         st_r.ref_en <= 1'b0;
         st_r.ref_val <= CCL_RST_REF_VAL;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Interrupt request needs all enables; wake needs the local and peripheral ones
   // since a cleared global enable still resumes execution
   assign irq_o = st_r.change_flag & st_r.irq_en &
      st_r.periph_en & st_r.global_en;
   assign wake_o = st_r.change_flag & st_r.irq_en & st_r.periph_en;

   // Reference settings driven to the ladder: 16 steps in each range
   assign ref_en_o = st_r.ref_en;
   assign ref_range_o = st_r.ref_range;
   assign ref_val_o = st_r.ref_val;
   assign reg_rdata_o = st_r.rdata;

endmodule : ccl_comparator_ctrl

// file: tb/ccl_comparator_ctrl_sva.sv
`timescale 1ns/1ps
module ccl_comparator_ctrl_sva
   import ccl_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Watched ports
   input wire ccl_bus_type bus_i,
   input wire logic [7:0] reg_rdata_o,
   input wire ccl_mux_type mux_o,
   input wire logic [1:0] gpio_read_o,
   input wire logic out_dir_i,
   input wire logic output_pin_o,
   input wire logic output_pin_oe_o,
   input wire logic irq_o,
   input wire logic wake_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   // Unused bits of control 0 read as zero
   property p_rsv;
      $past(bus_i.rd) && $past(bus_i.addr) == CCL_ADDR_CTRL0
         |-> reg_rdata_o[7] == 1'b0 && reg_rdata_o[5] == 1'b0;
   endproperty
   a_rsv: assert property (p_rsv)
      else $error("unused control bits read nonzero");
   // Direction bit still gates the pin driver
   property p_oe;
      output_pin_oe_o == (mux_o.pin_out_en && !out_dir_i);
   endproperty
   a_oe: assert property (p_oe)
      else $error("pin enable wrong");
   // No pin output outside pin modes
   property p_nopin;
      !mux_o.pin_out_en |-> !output_pin_o && !output_pin_oe_o;
   endproperty
   a_nopin: assert property (p_nopin)
      else $error("pin driven outside pin mode");
   // Off modes treat both pins as analog
   property p_offread;
      !mux_o.cmp_en |-> gpio_read_o == 2'h0;
   endproperty
   a_offread: assert property (p_offread)
      else $error("port read nonzero while off");
   // A pin routed to the comparator reads zero
   property p_analog;
      (!mux_o.ext_from_pos || !gpio_read_o[0])
         && (!mux_o.ext_from_neg || !gpio_read_o[1]);
   endproperty
   a_analog: assert property (p_analog)
      else $error("analog pin read nonzero");
   // Writing an off mode disables the comparator next cycle
   property p_offwr;
      bus_i.wr && bus_i.addr == CCL_ADDR_CTRL0
         && (bus_i.wdata[2:0] == 3'h0 || bus_i.wdata[2:0] == 3'h7)
         |=> !mux_o.cmp_en;
   endproperty
   a_offwr: assert property (p_offwr)
      else $error("comparator on after off mode write");
   // Request implies the wake condition
   property p_irq;
      irq_o |-> wake_o;
   endproperty
   a_irq: assert property (p_irq)
      else $error("request without wake");
   // Leaving reset: comparator off, no request, no data
   property p_rst;
      $fell(sys_rst_i) |-> !mux_o.cmp_en && !irq_o && reg_rdata_o == 8'h00;
   endproperty
   a_rst: assert property (p_rst)
      else $error("state after reset wrong");

   // Main scenarios
   c_irq: cover property (irq_o);
   c_pin: cover property (output_pin_oe_o);
   c_mux: cover property (mux_o.ext_from_pos);
endmodule : ccl_comparator_ctrl_sva

// file: tb/ccl_analog_model.sv
`timescale 1ns/1ps
module ccl_analog_model
   import ccl_pkg::*;
(
   // Switch settings and reference level
   input wire ccl_mux_type mux_i,
   input wire logic [3:0] ref_val_i,
   // Pin levels in arbitrary steps
   input wire logic [5:0] pos_lvl_i,
   input wire logic [5:0] neg_lvl_i,
   // Raw comparison
   output logic cmp_raw_o
);
   logic [5:0] plus_lvl;
   logic [5:0] minus_lvl;
   // Route pins and reference, then compare; off rests low
   always_comb begin
      plus_lvl = mux_i.plus_from_ref ? {ref_val_i, 2'h0} : pos_lvl_i;
      // Positive pin lands on minus only when it alone is routed
      minus_lvl = (mux_i.ext_from_pos && !mux_i.ext_from_neg) ?
         pos_lvl_i : neg_lvl_i;
      if (mux_i.minus_from_ref) begin
         minus_lvl = {ref_val_i, 2'h0};
      end
      cmp_raw_o = mux_i.cmp_en && (plus_lvl > minus_lvl);
   end
endmodule : ccl_analog_model

// file: tb/ccl_comparator_ctrl_tb.sv
`timescale 1ns/1ps
module ccl_comparator_ctrl_tb
   import ccl_pkg::*;
();
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   ccl_bus_type bus_i = '0;
   logic [7:0] reg_rdata_o;
   logic cmp_raw_i;
   ccl_mux_type mux_o;
   logic ref_en_o, ref_range_o, output_pin_o, output_pin_oe_o;
   logic [3:0] ref_val_o;
   logic [1:0] gpio_in_i = 2'h3;
   logic [1:0] gpio_read_o;
   logic out_dir_i = 1'b0;
   logic timer_src_clk_i = 1'b0;
   logic timer_pre_clk_i = 1'b0;
   logic timer_pre_en_i = 1'b0;
   logic external_gate_pin_i = 1'b0;
   logic timer_gate_o, irq_o, wake_o;
   logic [5:0] pos_lvl = 6'h32;
   logic [5:0] neg_lvl = 6'h0A;
   logic [7:0] rd_val;
   int miscompares = 0;
   int checks_done = 0;

   ccl_comparator_ctrl dut (
      .core_clk_i, .sys_rst_i, .bus_i, .reg_rdata_o, .cmp_raw_i, .mux_o,
      .ref_en_o, .ref_range_o, .ref_val_o, .gpio_in_i, .gpio_read_o,
      .out_dir_i, .output_pin_o, .output_pin_oe_o, .timer_src_clk_i,
      .timer_pre_clk_i, .timer_pre_en_i, .external_gate_pin_i,
      .timer_gate_o, .irq_o, .wake_o
   );
   ccl_analog_model u_analog (
      .mux_i(mux_o), .ref_val_i(ref_val_o), .pos_lvl_i(pos_lvl),
      .neg_lvl_i(neg_lvl), .cmp_raw_o(cmp_raw_i)
   );

   // 40 MHz system clock
   initial begin
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   task automatic chk(input string what, input logic [7:0] seen,
         input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic idle(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : idle

   // Bus cycles; strobe drops one edge later, so calls may follow
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk_i);
      bus_i.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge core_clk_i);
      bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk_i);
      bus_i.rd <= 1'b0;
      #1 rd_val = reg_rdata_o;
   endtask : rd

   task automatic do_reset();
      @(posedge core_clk_i);
      sys_rst_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
   endtask : do_reset

   // Timer clock step; the latch needs a few cycles to see it
   task automatic tclk(input logic pre, input logic lvl);
      @(posedge core_clk_i);
      timer_pre_clk_i <= pre ? lvl : timer_pre_clk_i;
      timer_src_clk_i <= pre ? timer_src_clk_i : lvl;
      idle(4);
   endtask : tclk

   task automatic t_reset();
      rd(CCL_ADDR_CTRL0);
      chk("ctrl0 reset", rd_val, 8'h00);
      rd(CCL_ADDR_CTRL1);
      chk("ctrl1 reset", rd_val, 8'h02);
      rd(CCL_ADDR_REF);
      chk("reference reset", rd_val, 8'h00);
      rd(8'h40);
      chk("unmapped read", rd_val, 8'h00);
   endtask : t_reset

   // Every mode: result, pin driver, port reads
   task automatic t_modes();
      logic [7:0] res_tab = 8'h7E;
      logic [7:0] pin_tab = 8'h2A;
      logic [7:0] dig_tab = 8'h0C;
      wr(CCL_ADDR_REF, 8'h08);
      for (int m = 0; m < 8; m++) begin
         wr(CCL_ADDR_CTRL0, 8'(m));
         idle(4);
         rd(CCL_ADDR_CTRL0);
         chk("mode", rd_val, {1'b0, res_tab[m], 3'h0, 3'(m)});
         chk("pin enable", 8'(output_pin_oe_o), 8'(pin_tab[m]));
         chk("pin level", 8'(output_pin_o), 8'(pin_tab[m]));
         chk("port read", 8'(gpio_read_o), {7'h00, dig_tab[m]});
      end
      wr(CCL_ADDR_CTRL0, 8'h0E);
      idle(4);
      rd(CCL_ADDR_CTRL0);
      chk("switched input", rd_val, 8'h0E);
   endtask : t_modes

   // Inversion, read-only result bit, direction gating
   task automatic t_invert();
      wr(CCL_ADDR_CTRL0, 8'h51);
      idle(4);
      rd(CCL_ADDR_CTRL0);
      chk("inverted status", rd_val, 8'h11);
      chk("inverted pin", 8'(output_pin_o), 8'h00);
      @(posedge core_clk_i);
      out_dir_i <= 1'b1;
      idle(1);
      chk("pin released", 8'(output_pin_oe_o), 8'h00);
      wr(CCL_ADDR_CTRL0, 8'h01);
      out_dir_i <= 1'b0;
      idle(4);
      rd(CCL_ADDR_CTRL0);
      chk("plain status", rd_val, 8'h41);
   endtask : t_invert

   // Change flag: masked set, re-set on mismatch, clear, software set
   task automatic t_flag();
      wr(CCL_ADDR_CTRL0, 8'h04);
      idle(4);
      rd(CCL_ADDR_CTRL0);
      wr(CCL_ADDR_IRQ, 8'h06);
      neg_lvl <= 6'h3C;
      idle(5);
      rd(CCL_ADDR_IRQ);
      chk("flag set", rd_val, 8'h07);
      chk("masked request", 8'(irq_o), 8'h00);
      chk("wake without global", 8'(wake_o), 8'h01);
      wr(CCL_ADDR_IRQ, 8'h06);
      rd(CCL_ADDR_IRQ);
      chk("flag re-set", rd_val, 8'h07);
      rd(CCL_ADDR_CTRL0);
      wr(CCL_ADDR_IRQ, 8'h06);
      rd(CCL_ADDR_IRQ);
      chk("flag cleared", rd_val, 8'h06);
      wr(CCL_ADDR_IRQ, 8'h0F);
      idle(1);
      chk("request", 8'(irq_o), 8'h01);
      wr(CCL_ADDR_IRQ, 8'h08);
      idle(1);
      chk("request gone", 8'(irq_o), 8'h00);
      chk("wake gone", 8'(wake_o), 8'h00);
   endtask : t_flag

   // Gate source, then the timer-clock latch with and without prescaler
   task automatic t_gate_sync();
      wr(CCL_ADDR_CTRL1, 8'h00);
      neg_lvl <= 6'h0A;
      idle(4);
      chk("gate from result", 8'(timer_gate_o), 8'h01);
      wr(CCL_ADDR_CTRL1, 8'h02);
      idle(3);
      chk("gate from pin", 8'(timer_gate_o), 8'h00);
      @(posedge core_clk_i);
      external_gate_pin_i <= 1'b1;
      idle(3);
      chk("gate pin high", 8'(timer_gate_o), 8'h01);
      @(posedge core_clk_i);
      external_gate_pin_i <= 1'b0;
      wr(CCL_ADDR_CTRL1, 8'h01);
      tclk(1'b0, 1'b1);
      tclk(1'b0, 1'b0);
      neg_lvl <= 6'h3C;
      idle(5);
      rd(CCL_ADDR_CTRL0);
      chk("held result", rd_val, 8'h44);
      @(posedge core_clk_i);
      timer_pre_en_i <= 1'b1;
      tclk(1'b0, 1'b1);
      tclk(1'b0, 1'b0);
      tclk(1'b1, 1'b1);
      rd(CCL_ADDR_CTRL0);
      chk("no latch yet", rd_val, 8'h44);
      tclk(1'b1, 1'b0);
      rd(CCL_ADDR_CTRL0);
      chk("latched result", rd_val, 8'h04);
      chk("latched gate", 8'(timer_gate_o), 8'h00);
   endtask : t_gate_sync

   task automatic t_ref();
      wr(CCL_ADDR_REF, 8'hFF);
      rd(CCL_ADDR_REF);
      chk("reference reg", rd_val, 8'hAF);
      chk("ref out", {ref_en_o, ref_range_o, 2'h0, ref_val_o}, 8'hCF);
   endtask : t_ref

   task automatic finish_test();
      if (miscompares == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test

   // Sequence, with a second reset mid-run
   initial begin
      do_reset();
      t_reset();
      t_modes();
      t_invert();
      t_flag();
      t_gate_sync();
      t_ref();
      do_reset();
      t_reset();
      finish_test();
   end

   // Watchdog: the sequence needs under a thousand cycles
   initial begin
      #50us;
      miscompares++;
      finish_test();
   end
endmodule : ccl_comparator_ctrl_tb

bind ccl_comparator_ctrl ccl_comparator_ctrl_sva u_sva (
   .core_clk_i, .sys_rst_i, .bus_i, .reg_rdata_o, .mux_o, .gpio_read_o,
   .out_dir_i, .output_pin_o, .output_pin_oe_o, .irq_o, .wake_o
);
